// *** core/pot_host_pkg.sv ***
/*
 * Constants for the host that steps a three-pin digital potentiometer.
 * Assumes a 20 MHz system clock; all pin timing is counted in its cycles.
 */
// How it works
// - Raising select with strobe high stores the position; host deselects so to save.
// - Raising select with strobe low skips the store; host deselects so for temporary settings.
// - The host holds direction steady while select stays low; it sets it only when a command selects.
// - The host avoids a falling strobe that coincides with a select edge.
package pot_host_pkg;
	localparam int CLK_MHZ = 20;
	// Pin timing in nanoseconds (least times)
	localparam int T_SETUP_NS = 100;
	localparam int T_STEP_LO_NS = 1000;
	localparam int T_STEP_HI_NS = 1000;
	localparam int T_RELEASE_NS = 1000;
	// Nonvolatile store time in microseconds
	localparam int T_STORE_US = 20000;
	localparam int NS_PER_US = 1000;
	localparam int TMR_W = 19;
	localparam int STEP_W = 7;

	// Least time in ns to whole cycles, rounded up, at least one
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
		return (c < 1) ? 1 : c;
	endfunction : ns_to_cyc

	// Timer load values: a state lasts load+1 cycles
	localparam logic [TMR_W-1:0] SETUP_LD = TMR_W'(ns_to_cyc(T_SETUP_NS) - 1);
	localparam logic [TMR_W-1:0] STEP_LO_LD = TMR_W'(ns_to_cyc(T_STEP_LO_NS) - 1);
	localparam logic [TMR_W-1:0] STEP_HI_LD = TMR_W'(ns_to_cyc(T_STEP_HI_NS) - 1);
	localparam logic [TMR_W-1:0] RELEASE_LD = TMR_W'(ns_to_cyc(T_RELEASE_NS) - 1);
	localparam logic [TMR_W-1:0] TMR_ZERO = 19'h00000;
	localparam logic [STEP_W-1:0] STEPS_ZERO = 7'h00;
	localparam logic [STEP_W-1:0] STEPS_ONE = 7'h01;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_STEP_LO,
		ST_STEP_HI,
		ST_RELEASE,
		ST_STORE
	} host_state_e;
endpackage : pot_host_pkg

// *** core/pot_wait_timer.sv ***
/*
 * Down-counting wait timer for pin phase timing.
 * Assumes the caller loads it on the edge that starts a phase.
 */
`timescale 1ns/1ps
`default_nettype none
module pot_wait_timer #(
	parameter int W = 19
) (
	input wire logic clk, // System clock
	input wire logic rstn, // Asynchronous reset, active low
	input wire logic load, // Load a new wait
	input wire logic [W-1:0] load_val, // Cycles to wait, minus one
	output logic expired // Count has reached zero
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	// Next count: load or count down to zero
	always_comb begin
		cnt_nxt = cnt_r;
		if (load) begin
			cnt_nxt = load_val;
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - W'(1);
		end
	end

	// Count register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign expired = (cnt_r == '0);
endmodule : pot_wait_timer
`default_nettype wire

// *** core/pot_host.sv ***
/*
 * Host controller for a three-pin up/down digital potentiometer.
 * Takes move commands (direction, step count, save flag) and drives the
 * select, step strobe and direction pins, ending with a store or no-store
 * deselect, or with only a done pulse for zero steps without save. Assumes command inputs are synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module pot_host #(
	parameter int STORE_CYC = pot_host_pkg::T_STORE_US * pot_host_pkg::CLK_MHZ
) (
	input wire logic clk, // 20 MHz system clock
	input wire logic rstn, // Asynchronous reset, active low
	input wire logic cmd_valid, // Command request
	output logic cmd_ready, // Ready to take a command
	input wire logic cmd_up, // 1 moves toward high end, 0 toward low end
	input wire logic [pot_host_pkg::STEP_W-1:0] cmd_steps, // Number of steps
	input wire logic cmd_save, // Store the position at deselect
	output logic cmd_done, // One-cycle pulse when a command ends
	output logic select_n, // Chip select pin, active low
	output logic step_n, // Step strobe pin, falling edge moves
	output logic up // Direction pin
);
	//********************************
	// State and pin registers
	//********************************
	pot_host_pkg::host_state_e state_r, state_nxt;
	logic select_n_r, select_n_nxt;
	logic step_n_r, step_n_nxt;
	logic up_r, up_nxt;
	logic ready_r, ready_nxt;
	logic done_r, done_nxt;
	logic save_r, save_nxt;
	logic [pot_host_pkg::STEP_W-1:0] left_r, left_nxt;
	logic tmr_load;
	logic [pot_host_pkg::TMR_W-1:0] tmr_val;
	logic tmr_expired;

	localparam logic [pot_host_pkg::TMR_W-1:0] STORE_LD = pot_host_pkg::TMR_W'(STORE_CYC - 1);

	//********************************
	// Phase timer
	//********************************
	pot_wait_timer #(
		.W(pot_host_pkg::TMR_W)
	) u_timer (
		.clk(clk),
		.rstn(rstn),
		.load(tmr_load),
		.load_val(tmr_val),
		.expired(tmr_expired)
	);

	//********************************
	// Sequencer next-state logic
	//********************************
	always_comb begin
		state_nxt = state_r;
		select_n_nxt = select_n_r;
		step_n_nxt = step_n_r;
		up_nxt = up_r;
		ready_nxt = ready_r;
		done_nxt = 1'b0;
		save_nxt = save_r;
		left_nxt = left_r;
		tmr_load = 1'b0;
		tmr_val = pot_host_pkg::TMR_ZERO;
		unique case (state_r)
			pot_host_pkg::ST_IDLE: begin
				// Standby: select and strobe high, device ignores pins
				select_n_nxt = 1'b1;
				step_n_nxt = 1'b1;
				ready_nxt = 1'b1;
				if (cmd_valid && ready_r) begin
					if (cmd_steps == pot_host_pkg::STEPS_ZERO && !cmd_save) begin
						done_nxt = 1'b1;
					end else begin
						// Select and set direction on the same clock edge
						select_n_nxt = 1'b0;
						up_nxt = cmd_up;
						save_nxt = cmd_save;
						left_nxt = cmd_steps;
						ready_nxt = 1'b0;
						tmr_load = 1'b1;
						tmr_val = pot_host_pkg::SETUP_LD;
						state_nxt = pot_host_pkg::ST_SETUP;
					end
				end
			end
			pot_host_pkg::ST_SETUP: begin
				if (tmr_expired) begin
					tmr_load = 1'b1;
					if (left_r == pot_host_pkg::STEPS_ZERO) begin
						// Save only: deselect with strobe high
						select_n_nxt = 1'b1;
						tmr_val = STORE_LD;
						state_nxt = pot_host_pkg::ST_STORE;
					end else begin
						step_n_nxt = 1'b0;
						left_nxt = left_r - pot_host_pkg::STEPS_ONE;
						tmr_val = pot_host_pkg::STEP_LO_LD;
						state_nxt = pot_host_pkg::ST_STEP_LO;
					end
				end
			end
			pot_host_pkg::ST_STEP_LO: begin
				if (tmr_expired) begin
					tmr_load = 1'b1;
					if (left_r == pot_host_pkg::STEPS_ZERO && !save_r) begin
						// Temporary setting: deselect with strobe still low
						select_n_nxt = 1'b1;
						tmr_val = pot_host_pkg::RELEASE_LD;
						state_nxt = pot_host_pkg::ST_RELEASE;
					end else begin
						step_n_nxt = 1'b1;
						tmr_val = pot_host_pkg::STEP_HI_LD;
						state_nxt = pot_host_pkg::ST_STEP_HI;
					end
				end
			end
			pot_host_pkg::ST_STEP_HI: begin
				if (tmr_expired) begin
					tmr_load = 1'b1;
					if (left_r == pot_host_pkg::STEPS_ZERO) begin
						// Last step done, strobe high: deselect to store
						select_n_nxt = 1'b1;
						tmr_val = STORE_LD;
						state_nxt = pot_host_pkg::ST_STORE;
					end else begin
						step_n_nxt = 1'b0;
						left_nxt = left_r - pot_host_pkg::STEPS_ONE;
						tmr_val = pot_host_pkg::STEP_LO_LD;
						state_nxt = pot_host_pkg::ST_STEP_LO;
					end
				end
			end
			pot_host_pkg::ST_RELEASE: begin
				// Strobe returns high only once select is high
				if (tmr_expired) begin
					step_n_nxt = 1'b1;
					ready_nxt = 1'b1;
					done_nxt = 1'b1;
					state_nxt = pot_host_pkg::ST_IDLE;
				end
			end
			pot_host_pkg::ST_STORE: begin
				// Wait out the nonvolatile write before reselecting
				if (tmr_expired) begin
					ready_nxt = 1'b1;
					done_nxt = 1'b1;
					state_nxt = pot_host_pkg::ST_IDLE;
				end
			end
			default: begin
				state_nxt = pot_host_pkg::ST_IDLE;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= pot_host_pkg::ST_IDLE;
			select_n_r <= 1'b1;
			step_n_r <= 1'b1;
			up_r <= 1'b0;
			ready_r <= 1'b0;
			done_r <= 1'b0;
			save_r <= 1'b0;
			left_r <= '0;
		end else begin
			state_r <= state_nxt;
			select_n_r <= select_n_nxt;
			step_n_r <= step_n_nxt;
			up_r <= up_nxt;
			ready_r <= ready_nxt;
			done_r <= done_nxt;
			save_r <= save_nxt;
			left_r <= left_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign select_n = select_n_r;
	assign step_n = step_n_r;
	assign up = up_r;
	assign cmd_ready = ready_r;
	assign cmd_done = done_r;
endmodule : pot_host
`default_nettype wire

// *** verification/pot_dev_model.sv ***
/*
 * Behavioural model of the three-pin potentiometer control section.
 * Assumes pins come from pot_host; pwr high means the part is powered.
 */
`timescale 1ns/1ps
`default_nettype none
module pot_dev_model #(
	parameter int STEP_TO_WIPER_DELAY = 100 // Overlap of old and new tap in ns, plain default
) (
	input wire logic select_n, // Select pin
	input wire logic step_n, // Strobe pin
	input wire logic up, // Direction pin
	input wire logic pwr, // Power present
	output logic [6:0] pos, // Wiper counter
	output logic [6:0] stored, // Nonvolatile copy
	output logic [99:0] taps // Tap switches closed
);
	// New tap makes before the old one breaks; one-hot once settled
	always @(pos) begin
		if (pos < 7'h64) taps[pos] = 1'b1;
		taps <= #(STEP_TO_WIPER_DELAY) (100'h1 << pos);
	end
	// Stored copy outlives power loss
	initial stored = 7'h00;
	// Power-up recall
	always @(posedge pwr) pos = stored;
	// Falling strobe moves one tap, saturating at 0 and 99
	always @(negedge step_n) if (pwr && !select_n) begin
		if (up && pos < 7'h63) pos = pos + 7'h01;
		else if (!up && pos > 7'h00) pos = pos - 7'h01;
	end
	// Deselect with strobe high stores, low skips
	always @(posedge select_n) if (pwr && step_n) stored = pos;
endmodule : pot_dev_model
`default_nettype wire

// *** verification/pot_host_properties.sv ***
/*
 * Pin timing checks for pot_host.
 * Assumes it is bound into every pot_host instance.
 */
`timescale 1ns/1ps
`default_nettype none
module pot_host_chk (
	input wire logic clk, // Clock
	input wire logic rstn, // Reset, active low
	input wire logic cmd_ready, // Idle flag
	input wire logic cmd_done, // End pulse
	input wire logic select_n, // Select pin
	input wire logic step_n, // Strobe pin
	input wire logic up // Direction pin
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_idle_pins_off: assert property (cmd_ready |-> select_n && step_n) else $error("pins active while idle");
	a_strobe_sel_apart: assert property ($fell(step_n) |-> $stable(select_n)) else $error("strobe at select edge");
	a_setup_gap: assert property ($fell(select_n) |-> step_n [*2]) else $error("strobe too soon");
	a_store_strobe_high: assert property ($rose(select_n) && step_n |-> $past(step_n)) else $error("strobe moved");
	a_nostore_release: assert property ($rose(select_n) && !step_n |->
		!step_n [*8] ##[12:13] (step_n && cmd_done)) else $error("bad release");
	a_dir_steady: assert property ($fell(step_n) |-> $stable(up) && !select_n) else $error("direction moved");
	a_done_single: assert property (cmd_done |-> cmd_ready ##1 !cmd_done) else $error("done not one cycle");
endmodule : pot_host_chk
bind pot_host pot_host_chk pot_host_chk_i (.clk(clk), .rstn(rstn), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
	.select_n(select_n), .step_n(step_n), .up(up));
`default_nettype wire

// *** verification/testbench.sv ***
/*
 * Self-checking bench: pot_host drives the device model.
 * Assumes a shortened store time.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk, rstn, cmd_valid, cmd_up, cmd_save, pwr;
	logic [6:0] cmd_steps, pos, stored;
	logic [99:0] taps;
	wire logic cmd_ready, cmd_done, select_n, step_n, up;
	int errors, samples_checked;
	pot_host #(.STORE_CYC(50)) pot_host_i (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_up(cmd_up), .cmd_steps(cmd_steps), .cmd_save(cmd_save), .cmd_done(cmd_done), .select_n(select_n),
		.step_n(step_n), .up(up));
	pot_dev_model pot_dev_model_i (.select_n(select_n), .step_n(step_n), .up(up), .pwr(pwr), .pos(pos),
		.stored(stored), .taps(taps));
	// 50 ns clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic complete_run;
		$display("checked %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [6:0] got, input logic [6:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
		end
	endtask : chk
	// One command, waited for under a bound
	task automatic cmd(input logic u, input logic [6:0] n, input logic s);
		int i;
		@(posedge clk);
		cmd_up <= u;
		cmd_steps <= n;
		cmd_save <= s;
		cmd_valid <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		for (i = 0; i < 9000 && cmd_done !== 1'b1; i++) @(negedge clk);
		if (i == 9000) begin
			errors++;
			complete_run();
		end
	endtask : cmd
	task automatic t_store;
		cmd(1'b1, 7'h05, 1'b1);
		chk(pos, 7'h05);
		chk(stored, 7'h05);
		chk(7'($countones(taps)), 7'h01);
		$display("t_store done");
	endtask : t_store
	task automatic t_temp;
		cmd(1'b0, 7'h02, 1'b0);
		chk(pos, 7'h03);
		chk(stored, 7'h05);
		pwr <= 1'b0;
		@(posedge clk);
		pwr <= 1'b1;
		@(posedge clk);
		chk(pos, 7'h05);
		$display("t_temp done");
	endtask : t_temp
	task automatic t_sat;
		cmd(1'b1, 7'h7F, 1'b0);
		chk(pos, 7'h63);
		chk({6'h00, taps[99]}, 7'h01);
		cmd(1'b0, 7'h7F, 1'b1);
		chk(pos, 7'h00);
		chk(stored, 7'h00);
		$display("t_sat done");
	endtask : t_sat
	task automatic t_zero;
		cmd(1'b1, 7'h01, 1'b1);
		cmd(1'b0, 7'h00, 1'b0);
		cmd(1'b0, 7'h00, 1'b1);
		chk(stored, 7'h01);
		chk(pos, 7'h01);
		$display("t_zero done");
	endtask : t_zero
	// Main sequence
	initial begin
		errors = 0;
		samples_checked = 0;
		rstn = 1'b0;
		pwr = 1'b0;
		cmd_valid = 1'b0;
		cmd_up = 1'b0;
		cmd_save = 1'b0;
		cmd_steps = 7'h00;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		pwr <= 1'b1;
		t_store();
		t_temp();
		t_sat();
		t_zero();
		complete_run();
	end
endmodule : testbench
`default_nettype wire
